// [logic/rftd_top.sv]
// reading filter, trigger sequencing, range lock and display formatting
// assumes readings arrive as one-cycle strobes after each meas_start pulse
// How it works
// - blank frequency below 9 Hz
// - dashes until valid measurement exists
// - overload flashes all H display
// - under-range flashes all L display
// - unsettled until window full or reading
// - average of 4, 16, 32 readings
// - full resolution from first reading in the window
// - filtered value feeds transfer computations
// - medium/slow adds digit in some ranges
// - large deviation restarts average from reading
// - threshold 1000, 100, 10 counts
// - threshold ignores extra digit
// - restart restarts fill count and unsettled
// - trigger press flushes filter
// - high-resolution adds digit like filter
// - auto ranging after power-up and reset
// - range lock holds range until auto
// - continuous mode restarts after each measurement
// - single-shot press abandons and restarts
// - filtered single-shot series stops when full
// - frequency decimal places by band
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rftd_top #(
   parameter int FLASH_CYCLES = rftd_pkg::FLASH_CYC
) (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic [31:0]               hrdata,
   output logic                      hresp,
   input  wire logic                 trig_key,
   input  wire rftd_pkg::rftd_rd_s   rd,
   output logic                      meas_start,
   output logic [1:0]                input_sel,
   output logic [3:0]                range_sel,
   output logic                      range_locked,
   output logic [23:0]               filt_value,
   output rftd_pkg::rftd_disp_s      disp
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic                 ready;
      logic                 wr_pend;
      logic [4:0]           wr_addr;
      logic [31:0]          hrdata;
      logic [1:0]           fmode;
      logic [1:0]           thr;
      logic                 xsel;
      logic                 single;
      logic [1:0]           in_sel;
      logic                 locked;
      logic [3:0]           range;
      logic [31:0][23:0]    win;
      logic [28:0]          sum;
      logic [5:0]           cnt;
      logic [4:0]           wp;
      logic                 have;
      logic                 busy;
      logic                 start;
      logic                 armed;
      logic                 over;
      logic                 under;
      logic [31:0]          freq;
      logic [23:0]          filt;
      logic [23:0]          fcnt;
      rftd_pkg::rftd_disp_s dsp;
   } rftd_state_s;

   rftd_state_s s_reg;
   rftd_state_s s_next;

   function automatic logic [5:0] win_len(input logic [1:0] m);
      case (m)
         rftd_pkg::FM_FAST: win_len = rftd_pkg::WIN_FAST;
         rftd_pkg::FM_MED:  win_len = rftd_pkg::WIN_MED;
         default:           win_len = rftd_pkg::WIN_SLOW;
      endcase
   endfunction

   function automatic logic [23:0] thr_val(input logic [1:0] t);
      case (t)
         rftd_pkg::TH_COARSE: thr_val = rftd_pkg::THR_COARSE;
         rftd_pkg::TH_MED:    thr_val = rftd_pkg::THR_MEDIUM;
         default:             thr_val = rftd_pkg::THR_FINE;
      endcase
   endfunction

   function automatic logic [2:0] freq_dec(input logic [31:0] f);
      if (f < rftd_pkg::F_B4A) begin
         freq_dec = 3'h2;
      end else if (f < rftd_pkg::F_B3A) begin
         freq_dec = 3'h4;
      end else if (f < rftd_pkg::F_B4B) begin
         freq_dec = 3'h3;
      end else if (f < rftd_pkg::F_B3B) begin
         freq_dec = 3'h4;
      end else if (f < rftd_pkg::F_B2B) begin
         freq_dec = 3'h3;
      end else begin
         freq_dec = 3'h2;
      end
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   logic        flush;
   logic        inval;
   logic        press;
   logic        restart;
   logic        xd;
   logic [23:0] diff;
   logic [5:0]  len;
   logic [15:0] mask;
   logic [31:0] cw;

   always_comb begin
      s_next = s_reg;
      flush = 1'b0;
      inval = 1'b0;
      press = trig_key;
      restart = 1'b0;
      diff = 24'h0;
      cw = hwdata;
      len = win_len(s_reg.fmode);
      s_next.ready = 1'b1;
      s_next.start = 1'b0;
      // bus: zero wait, read data registered in the address phase
      s_next.wr_pend = 1'b0;
      if (hsel && htrans[1] && hready) begin
         s_next.wr_pend = hwrite && (hsize == rftd_pkg::HSIZE_WORD);
         s_next.wr_addr = haddr[4:0];
         s_next.hrdata = 32'h0;
         if (!hwrite) begin
            case (haddr[4:0])
               rftd_pkg::OFF_CTRL: begin
                  s_next.hrdata[rftd_pkg::C_FMODE +: 2] = s_reg.fmode;
                  s_next.hrdata[rftd_pkg::C_THR +: 2] = s_reg.thr;
                  s_next.hrdata[rftd_pkg::C_XDIG] = s_reg.xsel;
                  s_next.hrdata[rftd_pkg::C_SINGLE] = s_reg.single;
                  s_next.hrdata[rftd_pkg::C_INSEL +: 2] = s_reg.in_sel;
                  s_next.hrdata[rftd_pkg::C_LOCK] = s_reg.locked;
                  s_next.hrdata[rftd_pkg::C_RANGE +: 4] = s_reg.range;
               end
               rftd_pkg::OFF_STAT: begin
                  s_next.hrdata[14:0] = {s_reg.dsp.xdig, s_reg.busy, s_reg.range,
                                         s_reg.locked, s_reg.dsp.fblank, s_reg.dsp.dec,
                                         s_reg.dsp.flash, s_reg.dsp.mode,
                                         s_reg.dsp.unsettled};
                  s_next.hrdata[21:16] = s_reg.cnt;
               end
               rftd_pkg::OFF_VALUE: s_next.hrdata[23:0] = s_reg.dsp.value;
               rftd_pkg::OFF_FREQ:  s_next.hrdata = s_reg.freq;
               rftd_pkg::OFF_FILT:  s_next.hrdata[23:0] = s_reg.filt;
               default:             s_next.hrdata = 32'h0;
            endcase
         end
      end
      if (s_reg.wr_pend) begin
         case (s_reg.wr_addr)
            rftd_pkg::OFF_CTRL: begin
               if (cw[rftd_pkg::C_RESET]) begin
                  // reset command restores defaults and auto ranging
                  cw = 32'h0;
               end
               s_next.fmode = cw[rftd_pkg::C_FMODE +: 2];
               s_next.thr = cw[rftd_pkg::C_THR +: 2];
               s_next.xsel = cw[rftd_pkg::C_XDIG];
               s_next.single = cw[rftd_pkg::C_SINGLE];
               s_next.in_sel = cw[rftd_pkg::C_INSEL +: 2];
               if (cw[rftd_pkg::C_LOCK]) begin
                  s_next.locked = 1'b1;
                  s_next.range = cw[rftd_pkg::C_RANGE +: 4];
               end
               if (cw[rftd_pkg::C_AUTO] || hwdata[rftd_pkg::C_RESET]) begin
                  s_next.locked = 1'b0;
               end
               inval = (s_next.in_sel != s_reg.in_sel) ||
                       (s_next.range != s_reg.range) || hwdata[rftd_pkg::C_RESET];
               flush = s_next.fmode != s_reg.fmode;
            end
            rftd_pkg::OFF_TRIG: press = press || hwdata[rftd_pkg::T_PRESS];
            default: ;
         endcase
      end
      // a finished reading; a same-cycle press, input or range change or reset command discards it
      if (rd.valid && s_reg.busy && !inval && !press) begin
         s_next.busy = 1'b0;
         s_next.have = 1'b1;
         s_next.over = rd.over;
         s_next.under = rd.under;
         s_next.freq = rd.freq;
         if (!s_reg.locked && rd.range != s_reg.range) begin
            s_next.range = rd.range;
            restart = 1'b1;
         end
         if (!rd.over && !rd.under) begin
            if (s_reg.fmode == rftd_pkg::FM_OFF) begin
               s_next.filt = rd.value;
               s_next.dsp.unsettled = 1'b0;
            end else begin
               diff = (rd.value > s_reg.filt) ? rd.value - s_reg.filt
                                              : s_reg.filt - rd.value;
               // reading units hold the extra digit, the threshold is scaled to match
               restart = restart || s_reg.cnt == 6'h0 ||
                         diff > thr_val(s_reg.thr);
               if (restart) begin
                  s_next.sum = {5'h0, rd.value};
                  s_next.cnt = 6'h1;
                  s_next.wp = 5'h1;
                  s_next.win[0] = rd.value;
               end else begin
                  s_next.win[s_reg.wp] = rd.value;
                  s_next.wp = s_reg.wp + 5'h1;
                  if (s_reg.cnt < len) begin
                     s_next.sum = s_reg.sum + {5'h0, rd.value};
                     s_next.cnt = s_reg.cnt + 6'h1;
                  end else begin
                     s_next.sum = s_reg.sum + {5'h0, rd.value} -
                                  {5'h0, s_reg.win[s_reg.wp - len[4:0]]};
                  end
               end
               s_next.dsp.unsettled = s_next.cnt < len;
               // full resolution from the first entry of the window
               s_next.filt = 24'(s_next.sum / {23'h0, s_next.cnt});
            end
         end
         if (s_reg.single && s_reg.armed && s_reg.fmode != rftd_pkg::FM_OFF &&
             s_next.dsp.unsettled) begin
            s_next.start = 1'b1;
            s_next.busy = 1'b1;
         end else begin
            s_next.armed = 1'b0;
         end
      end
      if (flush || inval || press) begin
         s_next.sum = 29'h0;
         s_next.cnt = 6'h0;
         s_next.wp = 5'h0;
         s_next.dsp.unsettled = 1'b1;
      end
      if (inval) begin
         s_next.have = 1'b0;
         s_next.over = 1'b0;
         s_next.under = 1'b0;
      end
      if (inval || press) begin
         // converter treats a start while busy as abandon and restart
         s_next.start = 1'b1;
         s_next.busy = 1'b1;
         s_next.armed = 1'b1;
      end
      if (!s_next.single && !s_next.busy) begin
         s_next.start = 1'b1;
         s_next.busy = 1'b1;
      end
      // display formatting
      mask = (s_next.in_sel == rftd_pkg::IN_WBND) ? rftd_pkg::XDIG_WBND
                                                  : rftd_pkg::XDIG_MAIN;
      xd = (s_next.fmode == rftd_pkg::FM_MED || s_next.fmode == rftd_pkg::FM_SLOW ||
            s_next.xsel) && mask[s_next.range];
      s_next.dsp.xdig = xd;
      s_next.dsp.value = xd ? s_next.filt : s_next.filt / rftd_pkg::XDIG_SCALE;
      s_next.dsp.dec = freq_dec(s_next.freq);
      s_next.dsp.fblank = s_next.freq < rftd_pkg::F_BLANK;
      if (!s_next.have) begin
         s_next.dsp.mode = rftd_pkg::DISP_DASH;
      end else if (s_next.over) begin
         s_next.dsp.mode = rftd_pkg::DISP_OVER;
      end else if (s_next.under) begin
         s_next.dsp.mode = rftd_pkg::DISP_UNDER;
      end else begin
         s_next.dsp.mode = rftd_pkg::DISP_NUM;
      end
      // flash phase runs free; the panel shows it only for H and L fills
      if (s_reg.fcnt >= 24'(FLASH_CYCLES - 1)) begin
         s_next.fcnt = 24'h0;
         s_next.dsp.flash = !s_reg.dsp.flash;
      end else begin
         s_next.fcnt = s_reg.fcnt + 24'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
         s_reg.ready <= 1'b1;
         s_reg.dsp.unsettled <= 1'b1;
         // no frequency seen yet, so the frequency field starts blank
         s_reg.dsp.fblank <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hreadyout = s_reg.ready;
   assign hrdata = s_reg.hrdata;
   assign hresp = 1'b0;
   assign meas_start = s_reg.start;
   assign input_sel = s_reg.in_sel;
   assign range_sel = s_reg.range;
   assign range_locked = s_reg.locked;
   assign filt_value = s_reg.filt;
   assign disp = s_reg.dsp;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic quiet;
   logic ctrl_wr;
   assign quiet = !s_reg.wr_pend && !trig_key;
   assign ctrl_wr = s_reg.wr_pend && s_reg.wr_addr == rftd_pkg::OFF_CTRL;

   blank_freq_a: assert property (
      s_reg.dsp.fblank == (s_reg.freq < rftd_pkg::F_BLANK))
      else $error("frequency blank out of step");
   dash_inval_a: assert property (
      ctrl_wr && hwdata[rftd_pkg::C_INSEL +: 2] != s_reg.in_sel
      |=> s_reg.dsp.mode == rftd_pkg::DISP_DASH && s_reg.start)
      else $error("input change did not show dashes");
   over_fill_a: assert property (
      quiet && s_reg.busy && rd.valid && rd.over
      |=> s_reg.dsp.mode == rftd_pkg::DISP_OVER)
      else $error("overload not displayed");
   under_fill_a: assert property (
      quiet && s_reg.busy && rd.valid && !rd.over && rd.under
      |=> s_reg.dsp.mode == rftd_pkg::DISP_UNDER)
      else $error("under-range not displayed");
   settle_off_a: assert property (
      quiet && s_reg.busy && rd.valid && !rd.over && !rd.under &&
      s_reg.fmode == rftd_pkg::FM_OFF |=> !s_reg.dsp.unsettled)
      else $error("unfiltered reading left unsettled");
   fill_state_a: assert property (
      s_reg.fmode != rftd_pkg::FM_OFF
      |-> s_reg.dsp.unsettled == (s_reg.cnt < win_len(s_reg.fmode)))
      else $error("unsettled flag disagrees with fill count");
   press_flush_a: assert property (
      trig_key |=> s_reg.start && s_reg.cnt == 6'h0 && s_reg.dsp.unsettled)
      else $error("trigger did not flush and restart");
   auto_reset_a: assert property (
      ctrl_wr && hwdata[rftd_pkg::C_RESET] |=> !s_reg.locked)
      else $error("reset command left range locked");
   lock_hold_a: assert property (
      s_reg.locked && !s_reg.wr_pend |=> $stable(s_reg.range) && s_reg.locked)
      else $error("locked range moved");
   cont_next_a: assert property (
      quiet && !s_reg.single && s_reg.busy && rd.valid |=> s_reg.start)
      else $error("continuous mode did not restart");
   series_stop_a: assert property (
      s_reg.single && !s_reg.busy && quiet |=> !s_reg.start)
      else $error("idle single-shot started sampling");
   dec_band_a: assert property (
      s_reg.freq >= rftd_pkg::F_B3A && s_reg.freq < rftd_pkg::F_B4B
      |-> s_reg.dsp.dec == 3'h3)
      else $error("wrong decimal places for kHz band");

   full_win_c: cover property (
      s_reg.fmode == rftd_pkg::FM_SLOW && $fell(s_reg.dsp.unsettled));
   over_c: cover property (s_reg.dsp.mode == rftd_pkg::DISP_OVER);
   series_c: cover property (
      s_reg.single && s_reg.fmode != rftd_pkg::FM_OFF && $fell(s_reg.armed));
endmodule
`default_nettype wire

// [common/rftd_pkg.sv]
// constants and carriers for the reading filter, trigger and display block
// assumes a 40 MHz hclk and readings in units one digit finer than normal
package rftd_pkg;
   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [4:0] OFF_CTRL  = 5'h00;
   localparam logic [4:0] OFF_TRIG  = 5'h04;
   localparam logic [4:0] OFF_STAT  = 5'h08;
   localparam logic [4:0] OFF_VALUE = 5'h0c;
   localparam logic [4:0] OFF_FREQ  = 5'h10;
   localparam logic [4:0] OFF_FILT  = 5'h14;
   localparam int C_FMODE = 0;
   localparam int C_THR   = 2;
   localparam int C_XDIG  = 4;
   localparam int C_SINGLE = 5;
   localparam int C_INSEL = 6;
   localparam int C_LOCK  = 8;
   localparam int C_RANGE = 9;
   localparam int C_AUTO  = 13;
   localparam int C_RESET = 31;
   localparam int T_PRESS = 0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // ************************************************************
   // modes and reset values
   // ************************************************************
   localparam logic [1:0] FM_OFF = 2'h0;
   localparam logic [1:0] FM_FAST = 2'h1;
   localparam logic [1:0] FM_MED = 2'h2;
   localparam logic [1:0] FM_SLOW = 2'h3;
   localparam logic [1:0] TH_COARSE = 2'h0;
   localparam logic [1:0] TH_MED = 2'h1;
   localparam logic [1:0] IN_WBND = 2'h2;
   localparam logic [5:0] WIN_FAST = 6'h04;
   localparam logic [5:0] WIN_MED = 6'h10;
   localparam logic [5:0] WIN_SLOW = 6'h20;
   // threshold counts 1000/100/10, scaled x10 into reading units
   localparam logic [23:0] THR_COARSE = 24'h002710;
   localparam logic [23:0] THR_MEDIUM = 24'h0003e8;
   localparam logic [23:0] THR_FINE   = 24'h000064;
   localparam logic [23:0] XDIG_SCALE = 24'h00000a;
   localparam logic [15:0] XDIG_MAIN = 16'h00ff;
   localparam logic [15:0] XDIG_WBND = 16'h03e0;
   // frequency bounds in 0.01 Hz: 9 Hz, 120 Hz, 1.2 k, 12 k, 1.2 M, 12 M
   localparam logic [31:0] F_BLANK = 32'h00000384;
   localparam logic [31:0] F_B4A = 32'h00002ee0;
   localparam logic [31:0] F_B3A = 32'h0001d4c0;
   localparam logic [31:0] F_B4B = 32'h00124f80;
   localparam logic [31:0] F_B3B = 32'h07270e00;
   localparam logic [31:0] F_B2B = 32'h47868c00;
   localparam int FLASH_MS = 250;
   localparam int CLK_KHZ = 40000;
   localparam int FLASH_CYC = FLASH_MS * CLK_KHZ;
   typedef enum logic [1:0] {DISP_DASH, DISP_NUM, DISP_OVER, DISP_UNDER} rftd_disp_e;
   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic        valid;
      logic        over;
      logic        under;
      logic [3:0]  range;
      logic [23:0] value;
      logic [31:0] freq;
   } rftd_rd_s;
   typedef struct packed {
      rftd_disp_e  mode;
      logic        flash;
      logic [2:0]  dec;
      logic        fblank;
      logic        unsettled;
      logic        xdig;
      logic [23:0] value;
   } rftd_disp_s;
endpackage

// [bench/rftd_conv_model.sv]
// converter stand-in: answers each meas_start not cut short by a later one with one reading strobe
// assumes the bench supplies value, frequency and flags; hold stalls delivery
`timescale 1ns/1ps
`default_nettype none
module rftd_conv_model (
   input  wire logic           hclk,
   input  wire logic           hresetn,
   input  wire logic           meas_start,
   input  wire logic           hold,
   input  wire logic           range_locked,
   input  wire logic [3:0]     range_sel,
   input  wire logic [23:0]    value_in,
   input  wire logic [31:0]    freq_in,
   input  wire logic [1:0]     flags_in,
   output rftd_pkg::rftd_rd_s  rd
);
   // ************************************************************
   // conversion timing
   // ************************************************************
   logic       busy;
   logic [2:0] cnt;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy <= 1'b0;
         cnt  <= 3'h0;
         rd   <= '0;
      end else begin
         rd.valid <= 1'b0;
         rd.value <= ~rd.value; // stale data must never pass for a reading
         if (meas_start) begin // a new start abandons the one under way
            busy <= 1'b1;
            cnt  <= 3'($urandom_range(5, 2));
         end else if (busy && !hold && cnt > 3'h1) begin
            cnt <= cnt - 3'h1;
         end else if (busy && !hold) begin
            busy <= 1'b0;
            rd   <= {1'b1, flags_in, range_locked ? range_sel : 4'h0, value_in, freq_in};
         end
      end
   end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the reading filter, trigger and display block
// assumes the converter model in rftd_conv_model and a 40 MHz hclk
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                 hclk, hresetn, hsel, hwrite, trig_key, hold, hreadyout, hresp;
   logic                 meas_start, range_locked;
   logic [31:0]          haddr, hwdata, hrdata, rdat, f_in;
   logic [1:0]           htrans, input_sel, flags;
   logic [2:0]           hsize;
   logic [3:0]           range_sel;
   logic [23:0]          filt_value, v_in, b, t;
   rftd_pkg::rftd_rd_s   rd;
   rftd_pkg::rftd_disp_s disp;
   int                   mismatches, n_checks, n0, w;
   int                   n_rd = 0;
   logic [31:0] ftab [13] = '{32'h00000383, 32'h00000384, 32'h00002edf, 32'h00002ee0,
      32'h0001d4bf, 32'h0001d4c0, 32'h00124f7f, 32'h00124f80, 32'h07270dff, 32'h07270e00,
      32'h47868bff, 32'h47868c00, 32'hb2d05e00};
   // flash shortened so a run sees it toggle
   rftd_top #(.FLASH_CYCLES(4)) i_rftd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .trig_key(trig_key), .rd(rd), .meas_start(meas_start), .input_sel(input_sel),
      .range_sel(range_sel), .range_locked(range_locked), .filt_value(filt_value),
      .disp(disp));
   rftd_conv_model i_rftd_conv_model (.hclk(hclk), .hresetn(hresetn), .meas_start(meas_start),
      .hold(hold), .range_locked(range_locked), .range_sel(range_sel), .value_in(v_in),
      .freq_in(f_in), .flags_in(flags), .rd(rd));
   // ************************************************************
   // clock, helpers and expectations
   // ************************************************************
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk) if (rd.valid === 1'b1) n_rd <= n_rd + 1;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ahb(input logic wr, input logic [4:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {27'h0, a};
      hsize  <= rftd_pkg::HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdat = hrdata;
   endtask
   // returns just after the cycle in which a reading lands
   task automatic wait_rd;
      @(posedge hclk);
      while (rd.valid !== 1'b1) @(posedge hclk);
      @(posedge hclk);
      #1;
   endtask
   // stall the converter so a settings write cannot race a reading
   task automatic quiet_wr(input logic [31:0] d);
      hold <= 1'b1;
      repeat (8) @(posedge hclk);
      ahb(1'b1, rftd_pkg::OFF_CTRL, d);
      hold <= 1'b0;
   endtask
   // readings carry one digit more, so counts are scaled by ten
   function automatic logic [23:0] thr_f(input int s);
      return (s == 0) ? 24'h002710 : (s == 1) ? 24'h0003e8 : 24'h000064;
   endfunction
   function automatic logic [2:0] dec_f(input logic [31:0] f);
      if (f < 32'h00002ee0) return 3'h2;
      if (f < 32'h0001d4c0) return 3'h4;
      if (f < 32'h00124f80) return 3'h3;
      if (f < 32'h07270e00) return 3'h4;
      if (f < 32'h47868c00) return 3'h3;
      return 3'h2;
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge hclk);
      mismatches++;
      final_report;
   end
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      {hsel, hwrite, trig_key, hold, hresetn, htrans, hsize, flags} = '0;
      {haddr, hwdata, f_in, v_in} = '0;
      {mismatches, n_checks} = '0;
      void'($urandom(32'h44453cfb));
      repeat (20) @(posedge hclk);
      chk("mode", 32'(rftd_pkg::DISP_DASH), 32'(disp.mode));
      chk("locked", 32'h0, 32'(range_locked));
      chk("fblank rst", 32'h1, 32'(disp.fblank));
      hresetn <= 1'b1;
      f_in <= 32'h000186a0;
      for (int m = 0; m < 4; m++) begin
         v_in <= 24'($urandom_range(900000, 1000));
         quiet_wr({30'h0, m[1:0]});
         w = (m == 0) ? 1 : (m == 1) ? 4 : (m == 2) ? 16 : 32;
         for (int k = 1; k <= w; k++) begin
            wait_rd;
            chk("unsettled", 32'(k < w), 32'(disp.unsettled));
         end
         chk("value", (m >= 2) ? 32'(v_in) : 32'(v_in / 24'h00000a), 32'(disp.value));
         chk("xdig", 32'(m >= 2), 32'(disp.xdig));
         chk("filt", 32'(v_in), 32'(filt_value));
         chk("num", 32'(rftd_pkg::DISP_NUM), 32'(disp.mode));
      end
      $display("filter windows done");
      for (int s = 0; s < 3; s++) begin
         b = 24'($urandom_range(900000, 1000));
         t = thr_f(s);
         v_in <= b;
         quiet_wr(32'h1 | (32'(s) << 2));
         repeat (4) wait_rd;
         v_in <= b + t;
         wait_rd;
         chk("no restart", 32'h0, 32'(disp.unsettled));
         v_in <= b + 24'h000003 * t;
         wait_rd;
         chk("restart", 32'h1, 32'(disp.unsettled));
         chk("fresh", 32'(b + 24'h000003 * t), 32'(filt_value));
         repeat (3) wait_rd;
         chk("refill", 32'h0, 32'(disp.unsettled));
      end
      ahb(1'b1, rftd_pkg::OFF_CTRL, 32'h00000011);
      wait_rd;
      chk("hires", 32'h1, 32'(disp.xdig));
      trig_key <= 1'b1;
      @(posedge hclk);
      trig_key <= 1'b0;
      #1;
      chk("press start", 32'h1, 32'(meas_start));
      chk("press flush", 32'h1, 32'(disp.unsettled));
      $display("threshold and trigger done");
      flags <= 2'h2;
      repeat (2) wait_rd;
      chk("over", 32'(rftd_pkg::DISP_OVER), 32'(disp.mode));
      flags <= 2'h1;
      repeat (2) wait_rd;
      chk("under", 32'(rftd_pkg::DISP_UNDER), 32'(disp.mode));
      flags <= 2'h0;
      for (int i = 0; i < 19; i++) begin
         f_in <= (i < 13) ? ftab[i] : 32'($urandom_range(32'hb2d05e00, 32'h384));
         repeat (2) wait_rd;
         chk("fblank", 32'(f_in < 32'h00000384), 32'(disp.fblank));
         if (f_in >= 32'h00000384) chk("dec", 32'(dec_f(f_in)), 32'(disp.dec));
      end
      $display("display formats done");
      ahb(1'b1, rftd_pkg::OFF_CTRL, 32'h00000b01);
      #1;
      chk("lock", 32'h1, 32'(range_locked));
      chk("dash", 32'(rftd_pkg::DISP_DASH), 32'(disp.mode));
      chk("flushed", 32'h1, 32'(disp.unsettled));
      repeat (2) wait_rd;
      ahb(1'b0, rftd_pkg::OFF_CTRL, 32'h0);
      chk("ctrl lock", 32'h0000000b, 32'(rdat[12:8]));
      chk("range", 32'h5, 32'(range_sel));
      ahb(1'b1, rftd_pkg::OFF_CTRL, 32'h00000b81);
      #1;
      chk("input", 32'h2, 32'(input_sel));
      chk("in dash", 32'(rftd_pkg::DISP_DASH), 32'(disp.mode));
      ahb(1'b1, rftd_pkg::OFF_CTRL, 32'h00002000);
      #1;
      chk("auto", 32'h0, 32'(range_locked));
      ahb(1'b1, rftd_pkg::OFF_CTRL, 32'h00000b00);
      ahb(1'b1, rftd_pkg::OFF_CTRL, 32'h80000000);
      #1;
      chk("reset auto", 32'h0, 32'(range_locked));
      ahb(1'b0, rftd_pkg::OFF_CTRL, 32'h0);
      chk("reset ctrl", 32'h0, 32'(rdat[8:0]));
      ahb(1'b0, 5'h1c, 32'h0);
      chk("unmapped", 32'h0, rdat);
      $display("range and bus done");
      quiet_wr(32'h00000021);
      hold <= 1'b1;
      ahb(1'b1, rftd_pkg::OFF_TRIG, 32'h00000001);
      n0 = n_rd;
      hold <= 1'b0;
      repeat (200) @(posedge hclk);
      chk("series", 32'h4, 32'(n_rd - n0));
      chk("series done", 32'h0, 32'(disp.unsettled));
      ahb(1'b1, rftd_pkg::OFF_CTRL, 32'h00000001);
      n0 = n_rd;
      repeat (100) @(posedge hclk);
      chk("continuous", 32'h1, 32'(n_rd - n0 > 8));
      #1;
      b[0] = disp.flash;
      repeat (4) @(posedge hclk);
      #1;
      chk("flash", 32'(!b[0]), 32'(disp.flash));
      chk("hresp", 32'h0, 32'(hresp));
      $display("trigger modes done");
      final_report;
   end
endmodule
`default_nettype wire
